// ---- common/dpsc_pkg.sv ----
/*
 * Constants shared by the dual potentiometer serial command port:
 * frame lengths, command encodings, reset values and timing counts.
 * Assumes a 250 MHz system clock; timings are derived from it here.
 */
package dpsc_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int CLK_MHZ = 250;
  // non-volatile write busy time, longest figure, in microseconds
  localparam int BUSY_MAX_US = 20000;
  // longest time converts exactly to whole cycles
  localparam int BUSY_CYC = BUSY_MAX_US * CLK_MHZ;
  // power-up recall completes within this time, in nanoseconds
  localparam int RECALL_MAX_NS = 5000;
  localparam int RECALL_CYC = (RECALL_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int BUSY_CNT_W = 23;
  localparam int RECALL_CNT_W = 12;

  // ---------------------------------------------------------------
  // frame shape
  // ---------------------------------------------------------------
  localparam logic [4:0] BITS_SHORT = 5'h08;
  localparam logic [4:0] BITS_LONG = 5'h10;
  localparam logic [4:0] BITS_SAT = 5'h11;
  // read-out: first driven edge, last data edge, standby edge
  localparam logic [3:0] RD_FIRST_EDGE = 4'h2;
  localparam logic [3:0] RD_LAST_EDGE = 4'h9;
  localparam logic [3:0] RD_DONE_EDGE = 4'hB;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] NV_RESET = 8'h80;
  localparam logic [7:0] WIPER_RESET = 8'h00;
  localparam logic [7:0] WIPER_MUTED = 8'h00;
  // pin order {mute, data, clock, select}; idle levels
  localparam logic [3:0] PIN_RESET = 4'h5;

  // ---------------------------------------------------------------
  // command encodings; the low two bits select channel A, B or both
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_WR_WIPER = 8'h00;
  localparam logic [7:0] CMD_WR_NV = 8'h10;
  localparam logic [7:0] CMD_CP_W2NV = 8'h20;
  localparam logic [7:0] CMD_CP_NV2W = 8'h30;
  localparam logic [7:0] CMD_RD_WIPER = 8'h68;
  localparam logic [7:0] CMD_RD_NV = 8'h28;
  localparam logic [1:0] CH_BOTH = 2'h3;
  localparam logic [1:0] CH_NONE = 2'h0;

  // ---------------------------------------------------------------
  // link state, gray coded along recall, standby, shift, read
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RECALL = 2'h2,
    ST_STANDBY = 2'h0,
    ST_SHIFT = 2'h1,
    ST_READ = 2'h3
  } dpsc_state_t;

endpackage : dpsc_pkg

// ---- hw/dpsc_sync.sv ----
/*
 * Two flip-flop synchroniser for a group of independent pin levels.
 * Assumes each bit is a slow level or a clock far below clk; bits are
 * not coherent with each other.
 */
`timescale 1ns/1ps
module dpsc_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // ---------------------------------------------------------------
  // two stages; first stage feeds only the second
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : dpsc_sync

// ---- hw/dpsc_port.sv ----
/*
 * Serial command port and control logic of a dual 256-position digital
 * potentiometer: three-wire link, wiper and non-volatile registers,
 * power-up recall, standby and non-volatile busy signalling.
 * Assumes the link pins are asynchronous to clk and the serial clock
 * stays well below clk/8 so that every edge is seen.
 */
`timescale 1ns/1ps
// Operation
// R1 - shift one bit per serial rising edge while selected
// R2 - execute on select rise, stop shifting there
// R3 - frames not 8 or 16 bits execute nothing
// R4 - host holds select low for whole frame
// R5 - writes: command byte then data byte, msb first
// R6 - copy and read accept 8 or 16 bits
// R7 - 0x01/0x02/0x03 write wiper A, B, both
// R8 - 0x11/0x12/0x13 store non-volatile A, B, both
// R9 - 0x21/0x22/0x23 copy wiper into non-volatile
// R10 - 0x31/0x32/0x33 copy non-volatile into wiper
// R11 - 0x69/0x6A read wiper, 0x29/0x2A read non-volatile
// R12 - standby when deselected, two clocks after read
// R13 - ready low during non-volatile write
// R14 - system keeps power during non-volatile write
// R15 - power-up recall loads wipers from non-volatile
// R16 - non-volatile default is mid-scale
// R17 - each wiper is an eight-bit tap position
// R18 - zero is low terminal, all ones high
// R19 - read data msb first from second edge
// R20 - mute zeroes wipers and blocks wiper commands
// R21 - non-volatile writes leave wipers unchanged
// R22 - undefined command bytes change nothing
module dpsc_port #(
  parameter int BUSY_CYCLES = dpsc_pkg::BUSY_CYC,
  parameter int RECALL_CYCLES = dpsc_pkg::RECALL_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic select_bar,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  input wire logic mute,
  output logic serial_data_out,
  output logic serial_data_oe,
  output logic [7:0] wiper_a_pos,
  output logic [7:0] wiper_b_pos,
  output logic ready_n,
  output logic standby
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (BUSY_CYCLES < 1 || BUSY_CYCLES >= (1 << dpsc_pkg::BUSY_CNT_W)) begin : g_busy_chk
    $error("BUSY_CYCLES out of range");
  end
  if (RECALL_CYCLES < 1 || RECALL_CYCLES >= (1 << dpsc_pkg::RECALL_CNT_W)) begin : g_rec_chk
    $error("RECALL_CYCLES out of range");
  end

  localparam logic [dpsc_pkg::BUSY_CNT_W-1:0] BUSY_LOAD =
    dpsc_pkg::BUSY_CNT_W'(BUSY_CYCLES);
  localparam logic [dpsc_pkg::RECALL_CNT_W-1:0] RECALL_LAST =
    dpsc_pkg::RECALL_CNT_W'(RECALL_CYCLES - 1);

  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [3:0] pin_s;
  logic sel_s, sclk_s, sdi_s, mute_s;
  logic sel_prev_q, sclk_prev_q;
  logic sel_rise, sel_fall, sclk_rise;

  dpsc_sync #(
    .WIDTH(4),
    .RESET_VAL(dpsc_pkg::PIN_RESET)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({mute, serial_data_in, serial_clock, select_bar}),
    .sync_out(pin_s)
  );

  // data and clock share the same delay, so the sampled bit lines up
  assign {mute_s, sdi_s, sclk_s, sel_s} = pin_s;

  // previous levels for edge detection, taken after the second stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else begin
      sel_prev_q <= sel_s;
      sclk_prev_q <= sclk_s;
    end
  end

  assign sel_rise = sel_s & ~sel_prev_q;
  assign sel_fall = ~sel_s & sel_prev_q;
  assign sclk_rise = sclk_s & ~sclk_prev_q;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  dpsc_pkg::dpsc_state_t state_q, state_d;
  logic [15:0] shift_q;
  logic [4:0] bits_q;
  logic [7:0] cmd, data;
  logic len_ok, len_long, exec;
  logic [1:0] dec_wr_w, dec_wr_nv, dec_w2nv, dec_nv2w;
  logic dec_rd, dec_rd_nv, dec_rd_b;
  logic [7:0] wiper_q [2];
  logic [7:0] nv_q [2];
  logic [7:0] pos_q [2];
  logic [dpsc_pkg::BUSY_CNT_W-1:0] busy_cnt_q;
  logic nv_busy, nv_start, ready_n_q, standby_q;
  logic [dpsc_pkg::RECALL_CNT_W-1:0] recall_cnt_q;
  logic recall_done;
  logic [7:0] rd_shift_q;
  logic [3:0] rd_edge_q, rd_edge_nxt;
  logic rd_step, sdo_q, oe_q;

  // ---------------------------------------------------------------
  // frame capture
  // ---------------------------------------------------------------
  // shifting only in SHIFT state; a rising select freezes the frame
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shift_q <= 16'h0000;
      bits_q <= 5'h00;
    end else if (sel_fall) begin
      shift_q <= 16'h0000;
      bits_q <= 5'h00;
    end else if (state_q == dpsc_pkg::ST_SHIFT && !sel_s && sclk_rise) begin // see R1
      shift_q <= {shift_q[14:0], sdi_s};
      // saturate so overlong frames never alias to a legal length
      if (bits_q != dpsc_pkg::BITS_SAT) begin
        bits_q <= bits_q + 5'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  assign len_long = (bits_q == dpsc_pkg::BITS_LONG);
  assign len_ok = len_long || (bits_q == dpsc_pkg::BITS_SHORT); // see R3
  assign exec = (state_q == dpsc_pkg::ST_SHIFT) && sel_rise; // see R2

  // in a 16-bit frame the trailing byte is data or don't care
  always_comb begin
    cmd = len_long ? shift_q[15:8] : shift_q[7:0]; // see R5
    data = shift_q[7:0];
    dec_wr_w = dpsc_pkg::CH_NONE;
    dec_wr_nv = dpsc_pkg::CH_NONE;
    dec_w2nv = dpsc_pkg::CH_NONE;
    dec_nv2w = dpsc_pkg::CH_NONE;
    dec_rd = 1'b0;
    dec_rd_nv = 1'b0;
    dec_rd_b = cmd[1];
    if (len_ok && cmd[1:0] != dpsc_pkg::CH_NONE) begin // see R22
      if (len_long && cmd[7:2] == dpsc_pkg::CMD_WR_WIPER[7:2]) begin
        dec_wr_w = cmd[1:0]; // see R7
      end else if (len_long && cmd[7:2] == dpsc_pkg::CMD_WR_NV[7:2]) begin
        dec_wr_nv = cmd[1:0]; // see R8
      end else if (cmd[7:2] == dpsc_pkg::CMD_CP_W2NV[7:2]) begin
        dec_w2nv = cmd[1:0]; // see R6, R9
      end else if (cmd[7:2] == dpsc_pkg::CMD_CP_NV2W[7:2]) begin
        dec_nv2w = cmd[1:0]; // see R6, R10
      end else if (cmd[1:0] != dpsc_pkg::CH_BOTH) begin
        // reading both channels has no encoding
        dec_rd = (cmd[7:2] == dpsc_pkg::CMD_RD_WIPER[7:2]) ||
                 (cmd[7:2] == dpsc_pkg::CMD_RD_NV[7:2]); // see R11
        dec_rd_nv = (cmd[7:2] == dpsc_pkg::CMD_RD_NV[7:2]);
      end
    end
  end

  // ---------------------------------------------------------------
  // wiper and non-volatile registers
  // ---------------------------------------------------------------
  assign nv_busy = (busy_cnt_q != '0);
  // a store while busy is dropped: the cell is still being written
  assign nv_start = exec && !nv_busy && ((dec_wr_nv | dec_w2nv) != dpsc_pkg::CH_NONE);

  // wiper registers: recall, writes and copies; mute blocks commands
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wiper_q[0] <= dpsc_pkg::WIPER_RESET;
      wiper_q[1] <= dpsc_pkg::WIPER_RESET;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        if (recall_done) begin
          wiper_q[ch] <= nv_q[ch]; // see R15
        end else if (exec && !mute_s) begin // see R20
          if (dec_wr_w[ch]) begin
            wiper_q[ch] <= data; // see R7, R17
          end else if (dec_nv2w[ch]) begin
            wiper_q[ch] <= nv_q[ch]; // see R10
          end
        end
      end
    end
  end

  // non-volatile registers; sys_rst models a fresh factory part
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nv_q[0] <= dpsc_pkg::NV_RESET; // see R16
      nv_q[1] <= dpsc_pkg::NV_RESET; // see R16
    end else if (nv_start) begin
      for (int ch = 0; ch < 2; ch++) begin
        if (dec_wr_nv[ch]) begin
          nv_q[ch] <= data; // see R8, R21
        end else if (dec_w2nv[ch]) begin
          nv_q[ch] <= wiper_q[ch]; // see R9
        end
      end
    end
  end

  // busy timer; power must stay up while it runs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_cnt_q <= '0;
    end else if (nv_start) begin
      busy_cnt_q <= BUSY_LOAD; // see R13, R14
    end else if (nv_busy) begin
      busy_cnt_q <= busy_cnt_q - 1'b1;
    end
  end

  // tap outputs; code 0 is the low terminal end, 0xFF the high end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pos_q[0] <= dpsc_pkg::WIPER_RESET;
      pos_q[1] <= dpsc_pkg::WIPER_RESET;
      ready_n_q <= 1'b1;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        pos_q[ch] <= mute_s ? dpsc_pkg::WIPER_MUTED : wiper_q[ch]; // see R18, R20
      end
      ready_n_q <= !nv_busy; // see R13
    end
  end

  // ---------------------------------------------------------------
  // power-up recall timer
  // ---------------------------------------------------------------
  assign recall_done = (state_q == dpsc_pkg::ST_RECALL) && (recall_cnt_q == RECALL_LAST);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      recall_cnt_q <= '0;
    end else if (state_q == dpsc_pkg::ST_RECALL) begin
      recall_cnt_q <= recall_cnt_q + 1'b1; // see R15
    end
  end

  // ---------------------------------------------------------------
  // link state machine
  // ---------------------------------------------------------------
  assign rd_step = (state_q == dpsc_pkg::ST_READ) && sel_s && sclk_rise;
  assign rd_edge_nxt = rd_edge_q + 4'h1;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      dpsc_pkg::ST_RECALL: begin
        if (recall_done) begin
          state_d = dpsc_pkg::ST_STANDBY;
        end
      end
      dpsc_pkg::ST_STANDBY: begin
        if (sel_fall) begin
          state_d = dpsc_pkg::ST_SHIFT; // see R1
        end
      end
      dpsc_pkg::ST_SHIFT: begin
        if (sel_rise) begin
          state_d = dec_rd ? dpsc_pkg::ST_READ : dpsc_pkg::ST_STANDBY; // see R2
        end
      end
      dpsc_pkg::ST_READ: begin
        if (sel_fall) begin
          state_d = dpsc_pkg::ST_SHIFT;
        end else if (rd_step && rd_edge_nxt == dpsc_pkg::RD_DONE_EDGE) begin
          state_d = dpsc_pkg::ST_STANDBY; // see R12
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= dpsc_pkg::ST_RECALL;
      standby_q <= 1'b0;
    end else begin
      state_q <= state_d;
      standby_q <= (state_d == dpsc_pkg::ST_STANDBY); // see R12
    end
  end

  // ---------------------------------------------------------------
  // read-out shifter and data pin drive
  // ---------------------------------------------------------------
  // pin stays driven until select falls, even after standby
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_shift_q <= 8'h00;
      rd_edge_q <= 4'h0;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (sel_fall) begin
      oe_q <= 1'b0; // see R19
    end else if (exec && dec_rd) begin
      rd_shift_q <= dec_rd_nv ? nv_q[dec_rd_b] : wiper_q[dec_rd_b]; // see R11
      rd_edge_q <= 4'h0;
    end else if (rd_step) begin
      rd_edge_q <= rd_edge_nxt;
      if (rd_edge_nxt >= dpsc_pkg::RD_FIRST_EDGE && rd_edge_nxt <= dpsc_pkg::RD_LAST_EDGE) begin
        sdo_q <= rd_shift_q[7]; // see R19
        rd_shift_q <= {rd_shift_q[6:0], 1'b0};
        oe_q <= 1'b1;
      end
    end
  end

  assign serial_data_out = sdo_q;
  assign serial_data_oe = oe_q;
  assign wiper_a_pos = pos_q[0];
  assign wiper_b_pos = pos_q[1];
  assign ready_n = ready_n_q;
  assign standby = standby_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_wr_wiper_a;
    exec && dec_wr_w[0] && !mute_s;
  endsequence
  sequence s_rd_launch;
    exec && dec_rd;
  endsequence
  sequence s_rd_first;
    rd_step && rd_edge_q == 4'h1 && !sel_fall;
  endsequence
  sequence s_rd_idle_edge;
    rd_step && rd_edge_q == 4'h0;
  endsequence

  a_bit_shift: assert property ( // see R1
    state_q == dpsc_pkg::ST_SHIFT && !sel_s && sclk_rise && !sel_fall
    |=> shift_q[0] == $past(sdi_s) && bits_q != 5'h00)
    else $error("serial bit not shifted in");
  a_wiper_write: assert property ( // see R2
    s_wr_wiper_a |=> wiper_q[0] == $past(data) ##1 ($past(mute_s) || pos_q[0] == $past(wiper_q[0])))
    else $error("wiper A write not applied");
  a_bad_length: assert property ( // see R3
    exec && !len_ok |=> $stable(wiper_q[0]) && $stable(wiper_q[1]) &&
    $stable(nv_q[0]) && $stable(nv_q[1]) && state_q == dpsc_pkg::ST_STANDBY)
    else $error("odd length frame executed");
  a_short_write: assert property ( // see R5
    exec && bits_q == dpsc_pkg::BITS_SHORT |-> dec_wr_w == 2'h0 && dec_wr_nv == 2'h0)
    else $error("eight bit write accepted");
  a_nv_store: assert property ( // see R8
    exec && dec_wr_nv[0] && !nv_busy |=> nv_q[0] == $past(data) && $stable(wiper_q[0]))
    else $error("non-volatile store wrong");
  a_copy_to_nv: assert property ( // see R9
    exec && dec_w2nv[1] && !nv_busy |=> nv_q[1] == $past(wiper_q[1]))
    else $error("wiper to non-volatile copy wrong");
  a_copy_to_wiper: assert property ( // see R10
    exec && dec_nv2w[0] && !mute_s |=> wiper_q[0] == $past(nv_q[0]))
    else $error("non-volatile to wiper copy wrong");
  a_read_launch: assert property ( // see R19
    s_rd_launch |=> state_q == dpsc_pkg::ST_READ && !serial_data_oe)
    else $error("read not launched with pin released");
  a_read_idle: assert property ( // see R19
    s_rd_idle_edge |=> !serial_data_oe)
    else $error("data pin driven on first edge");
  a_read_msb: assert property ( // see R19
    s_rd_first |=> serial_data_oe && serial_data_out == $past(rd_shift_q[7]))
    else $error("read msb not driven on second edge");
  a_standby_entry: assert property ( // see R12
    rd_step && rd_edge_q == 4'hA && !sel_fall |=> standby && state_q == dpsc_pkg::ST_STANDBY)
    else $error("no standby after read");
  a_busy_ready: assert property ( // see R13
    nv_start |-> ##2 !ready_n)
    else $error("ready not low during store");
  a_recall_load: assert property ( // see R15
    recall_done |=> wiper_q[0] == nv_q[0] && wiper_q[1] == nv_q[1])
    else $error("power-up recall missing");
  a_mute_zero: assert property ( // see R20
    mute_s |=> wiper_a_pos == 8'h00 && wiper_b_pos == 8'h00)
    else $error("mute did not zero wipers");
  a_undef_cmd: assert property ( // see R22
    exec && !dec_rd && (dec_wr_w | dec_wr_nv | dec_w2nv | dec_nv2w) == 2'h0
    |=> $stable(wiper_q[0]) && $stable(wiper_q[1]) && $stable(nv_q[0]) && $stable(nv_q[1]))
    else $error("undefined command changed state");

endmodule : dpsc_port

// ---- hw/README_unused.sv ----
`timescale 1ns/1ps

// ---- tb/dpsc_host.sv ----
/*
 * Behavioural host for the serial command port: command frames and read-out.
 * Assumes the bench resolves the shared data pin and calls these tasks.
 */
`timescale 1ns/1ps
module dpsc_host (
  input wire logic clk,
  input wire logic sdio,
  output logic select_bar,
  output logic serial_clock,
  output logic data_drv,
  output logic data_oe
);
  // idle levels; serial clock rests low between frames
  initial begin
    select_bar = 1'b1;
    serial_clock = 1'b0;
    data_drv = 1'b1;
    data_oe = 1'b0;
  end

  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask : ticks

  // half period of the 64 ns link clock is 8 system cycles
  task automatic send(input logic [15:0] w, input int n);
    select_bar = 1'b0;
    data_oe = 1'b1;
    ticks(12);
    for (int i = n - 1; i >= 0; i--) begin
      data_drv = w[i];
      ticks(8);
      serial_clock = 1'b1;
      ticks(8);
      serial_clock = 1'b0;
    end
    ticks(4);
    select_bar = 1'b1;
    data_oe = 1'b0; // released pin shows the inverse
    ticks(60);
  endtask : send

  // select stays high; bits sampled half a period after falling edges 2 to 9
  task automatic readout(output logic [7:0] v);
    v = 8'h00;
    for (int k = 1; k <= 11; k++) begin
      ticks(8);
      if (k >= 3 && k <= 10) begin
        v[10 - k] = sdio;
      end
      serial_clock = 1'b1;
      ticks(8);
      serial_clock = 1'b0;
    end
    ticks(8);
  endtask : readout

  // empty frame: aborts drive, executes nothing
  task automatic blip();
    select_bar = 1'b0;
    ticks(16);
    select_bar = 1'b1;
    ticks(60);
  endtask : blip
endmodule : dpsc_host

// ---- tb/dual_pot_serial_command_port_tb.sv ----
/*
 * Self-checking bench for the serial command port.
 * Assumes shortened busy and recall counts; the host model drives the link.
 */
`timescale 1ns/1ps
module dual_pot_serial_command_port_tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk, sys_rst, mute, sdio;
  logic select_bar, serial_clock, data_drv, data_oe;
  logic serial_data_out, serial_data_oe, ready_n, standby;
  logic [7:0] wiper_a_pos, wiper_b_pos;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;

  // wire level from both drivers' enables
  assign sdio = serial_data_oe ? serial_data_out : (data_oe ? data_drv : ~data_drv);

  // busy must outlast the host's 60-cycle tail so the low ready is seen
  dpsc_port #(.BUSY_CYCLES(200), .RECALL_CYCLES(8)) dut (
    .clk(clk), .sys_rst(sys_rst), .select_bar(select_bar),
    .serial_clock(serial_clock), .serial_data_in(sdio), .mute(mute),
    .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
    .wiper_a_pos(wiper_a_pos), .wiper_b_pos(wiper_b_pos),
    .ready_n(ready_n), .standby(standby)
  );

  dpsc_host host (
    .clk(clk), .sdio(sdio), .select_bar(select_bar), .serial_clock(serial_clock),
    .data_drv(data_drv), .data_oe(data_oe)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // hang guard, well above the whole run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wipers(input logic [7:0] a, input logic [7:0] b);
    check("wiper_a_pos", {8'h00, wiper_a_pos}, {8'h00, a});
    check("wiper_b_pos", {8'h00, wiper_b_pos}, {8'h00, b});
  endtask : wipers

  // non-volatile write: busy must show, then clear in bounded time
  task automatic store(input logic [15:0] w, input int n);
    host.send(w, n);
    check("ready_n busy", {15'h0, ready_n}, 16'h0000);
    for (int i = 0; i < 400 && ready_n !== 1'b1; i++) @(negedge clk);
    check("ready_n done", {15'h0, ready_n}, 16'h0001);
  endtask : store

  task automatic rd(input logic [15:0] w, input int n, input logic [7:0] exp);
    logic [7:0] v;
    host.send(w, n);
    host.readout(v);
    check("read data", {8'h00, v}, {8'h00, exp});
    check("standby after read", {15'h0, standby}, 16'h0001);
    check("oe held", {15'h0, serial_data_oe}, 16'h0001);
    host.blip();
    check("oe after fall", {15'h0, serial_data_oe}, 16'h0000);
  endtask : rd

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_powerup();
    wipers(8'h00, 8'h00);
    for (int i = 0; i < 100 && standby !== 1'b1; i++) @(negedge clk);
    check("standby", {15'h0, standby}, 16'h0001);
    // tap outputs follow the recalled wipers one clock after standby
    repeat (2) @(negedge clk);
    wipers(8'h80, 8'h80);
    check("ready_n idle", {15'h0, ready_n}, 16'h0001);
  endtask : t_powerup

  // both ends of the tap range and every channel code
  task automatic t_write();
    logic [31:0] tbl [4] = '{32'h015A5A80, 32'h02FF5AFF, 32'h03000000, 32'h01FFFF00};
    foreach (tbl[i]) begin
      host.send(tbl[i][31:16], 16);
      wipers(tbl[i][15:8], tbl[i][7:0]);
    end
  endtask : t_write

  // wrong counts, short writes and undefined bytes change nothing
  task automatic t_bad();
    logic [15:0] w [6] = '{16'h0015, 16'h0001, 16'h0155, 16'h6B11, 16'h0411, 16'h1022};
    int n [6] = '{12, 8, 15, 16, 16, 16};
    foreach (w[i]) begin
      host.send(w[i], n[i]);
      wipers(8'hFF, 8'h00);
      check("ready_n", {15'h0, ready_n}, 16'h0001);
    end
  endtask : t_bad

  task automatic t_store();
    store(16'h133C, 16);
    wipers(8'hFF, 8'h00);
    host.send(16'h0031, 8);
    wipers(8'h3C, 8'h00);
    host.send(16'h32AA, 16);
    wipers(8'h3C, 8'h3C);
    store(16'h1121, 16);
    store(16'h1242, 16);
    host.send(16'h0033, 8);
    wipers(8'h21, 8'h42);
  endtask : t_store

  task automatic t_copy_read();
    rd(16'h0069, 8, 8'h21);
    rd(16'h006A, 8, 8'h42);
    rd(16'h0029, 8, 8'h21);
    rd(16'h002A, 8, 8'h42);
    host.send(16'h0111, 16);
    host.send(16'h0299, 16);
    store(16'h21FF, 16);
    store(16'h0022, 8);
    rd(16'h0029, 8, 8'h11);
    rd(16'h002A, 8, 8'h99);
    host.send(16'h0377, 16);
    store(16'h0023, 8);
    rd(16'h2900, 16, 8'h77);
    rd(16'h6AFF, 16, 8'h77);
  endtask : t_copy_read

  task automatic t_mute();
    mute = 1'b1;
    repeat (10) @(negedge clk);
    wipers(8'h00, 8'h00);
    host.send(16'h0112, 16);
    host.send(16'h0033, 8);
    mute = 1'b0;
    repeat (10) @(negedge clk);
    wipers(8'h77, 8'h77);
    rd(16'h0029, 8, 8'h77);
  endtask : t_mute

  task automatic final_report();
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    mute = 1'b0;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    t_powerup();
    t_write();
    t_bad();
    t_store();
    t_copy_read();
    t_mute();
    final_report();
  end
endmodule : dual_pot_serial_command_port_tb
